// ===== th_params.svh
// Constants for the tag host serial port and interrupt pin
`ifndef TH_PARAMS_SVH
`define TH_PARAMS_SVH

`define TH_CLK_PERIOD_NS 50
`define TH_WAIT_TICK_NS 1000
`define TH_TICK_CYC ((`TH_WAIT_TICK_NS + `TH_CLK_PERIOD_NS - 1) / `TH_CLK_PERIOD_NS)

`define TH_BYTE_BITS 4'h8
`define TH_FIRST_TX_BITS 4'h1
`define TH_DIR_READ 1'b1
`define TH_SELF_DIAG_LO 4'hB
`define TH_IDLE_BYTE 8'hFF
`define TH_RSP_MAX_BYTES 8'hFF

`define TH_SRC_FIELD 0
`define TH_SRC_TX 1
`define TH_SRC_READ 2
`define TH_SRC_WRITE 3
`define TH_MASK_LSB 4
`define TH_MASK_MSB 7
`define TH_MASK_RESET 4'h0

`endif

// ===== th_pkg.sv
// Types shared by the tag host serial port
package th_pkg;
    typedef enum logic [2:0] {
        TH_IDLE = 3'b000,
        TH_ADDR = 3'b001,
        TH_ADDR_ACK = 3'b010,
        TH_WR = 3'b011,
        TH_WR_ACK = 3'b100,
        TH_RD = 3'b101,
        TH_RD_ACK = 3'b110,
        TH_WAIT = 3'b111
    } th_i2c_st_t;
endpackage

// ===== th_serial_irq_port.sv
// Host serial slave port with interrupt pin of a dual-interface tag
`timescale 1ns/1ns
`include "th_params.svh"

module th_serial_irq_port
    import th_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h52,
    parameter int BUF_DEPTH = 2
)(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt pin
    output logic irq_out_n,
    // System area settings
    input wire logic [7:0] resume_wait_time,
    input wire logic [7:0] inter_edge_wait_time,
    input wire logic [3:0] irq_source_select,
    input wire logic [15:0] read_irq_block_start,
    input wire logic [15:0] read_irq_block_end,
    // Supply and field state
    input wire logic external_supply,
    input wire logic field_present,
    // Control byte of write_control_cmd
    input wire logic ctrl_we,
    input wire logic [7:0] ctrl_data,
    output logic [3:0] irq_mask,
    // RF side events
    input wire logic rf_write_start,
    input wire logic rf_read_resp_sent,
    input wire logic [15:0] rf_read_addr,
    input wire logic rf_tx_done,
    input wire logic rf_field_detect,
    input wire logic tunnel_detect,
    // Command byte stream to the executor
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    output logic cmd_first,
    input wire logic cmd_ready,
    output logic cmd_abort,
    // Response from the executor
    input wire logic cmd_done,
    input wire logic [7:0] dev_status,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    output logic rsp_ready,
    output logic rsp_flush,
    output logic edge_timeout
);
    localparam int TICK_CYC = `TH_TICK_CYC;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    generate
        if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || TICK_CYC < 1 || TICK_CYC > 256) begin : g_chk
            $error("th_serial_irq_port: unsupported parameter value");
        end
    endgenerate

    th_i2c_st_t st_q;
    logic scl_p_q, sda_p_q, sda_oe_q, sda_out_q, dir_q, xfer_q, new_cmd_q;
    logic [3:0] bit_q;
    logic [7:0] rx_q, tx_q, tick_q, res_tick_q, edge_tick_q, rsp_cnt_q;
    logic res_run_q, cmd_wait_q, cmd_cont_q, rsp_pend_q, rsp_cont_q;
    logic irq_n_q, abort_q, flush_q, rdy_q, eto_q, cmd_valid_q;
    logic [3:0] mask_q;
    logic [8:0] buf_q [BUF_DEPTH];
    logic [CNT_W-1:0] buf_cnt_q;

    // Bus conditions, inputs already synchronous to sys_clk
    wire scl_rise = scl_in && !scl_p_q;
    wire scl_fall = !scl_in && scl_p_q;
    wire start_det = scl_in && scl_p_q && sda_p_q && !sda_in;
    wire stop_det = scl_in && scl_p_q && !sda_p_q && sda_in;
    wire byte_done = scl_fall && bit_q == `TH_BYTE_BITS;
    wire addr_hit = st_q == TH_ADDR && byte_done && rx_q[7:1] == SLAVE_ADDR;
    wire rd_hit = addr_hit && rx_q[0] == `TH_DIR_READ;
    wire wr_hit = addr_hit && rx_q[0] != `TH_DIR_READ;
    wire tick = tick_q == 8'(TICK_CYC - 1);
    wire edge_to = xfer_q && tick && edge_tick_q >= inter_edge_wait_time;
    wire end_evt = xfer_q && (start_det || stop_det || edge_to);
    wire wr_end = end_evt && !dir_q;
    wire rd_end = end_evt && dir_q;
    wire res_expire = res_run_q && tick && res_tick_q >= resume_wait_time;

    // Command buffer; a full buffer refuses the byte with a not-acknowledge
    wire buf_full = buf_cnt_q == CNT_W'(BUF_DEPTH);
    wire buf_pop = cmd_valid_q && cmd_ready;
    wire wr_byte = st_q == TH_WR && byte_done;
    wire buf_push = wr_byte && !buf_full;
    wire [CNT_W-1:0] buf_cnt_d = buf_cnt_q + CNT_W'(buf_push) - CNT_W'(buf_pop);
    wire [CNT_W-1:0] wr_idx = buf_cnt_q - CNT_W'(buf_pop);
    wire [8:0] push_word = {new_cmd_q, rx_q};

    // Read byte source
    wire rd_first = st_q == TH_ADDR_ACK;
    wire rd_load = scl_fall && ((rd_first && dir_q) || st_q == TH_RD_ACK);
    wire rsp_ok = rsp_pend_q && rsp_valid && rsp_cnt_q < `TH_RSP_MAX_BYTES;
    wire [7:0] diag_byte = {dev_status[7:4], `TH_SELF_DIAG_LO};
    wire [7:0] first_byte = !rsp_pend_q ? dev_status : (rsp_cont_q ? diag_byte : rsp_data);
    wire [7:0] rd_byte = rd_first ? first_byte : (rsp_ok ? rsp_data : `TH_IDLE_BYTE);
    wire rsp_take = rd_load && rsp_ok && !(rd_first && rsp_cont_q);
    wire rsp_split = rsp_pend_q && !rsp_cont_q && rsp_ok;

    // Interrupt sources and pin
    wire in_region = rf_read_addr >= read_irq_block_start && rf_read_addr <= read_irq_block_end;
    wire [3:0] rf_src = {rf_write_start, rf_read_resp_sent && in_region, rf_tx_done,
        rf_field_detect};
    wire [3:0] rf_ev = rf_src & irq_source_select & ~mask_q;
    wire irq_set = cmd_done || tunnel_detect || (|rf_ev);
    wire field_lost = !field_present && !external_supply;
    wire irq_clr = rd_hit || field_lost;

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign irq_out_n = irq_n_q;
    assign irq_mask = mask_q;
    assign cmd_valid = cmd_valid_q;
    assign cmd_data = buf_q[0][7:0];
    assign cmd_first = buf_q[0][8];
    assign cmd_abort = abort_q;
    assign rsp_ready = rdy_q;
    assign rsp_flush = flush_q;
    assign edge_timeout = eto_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            tick_q <= 8'h00;
            sda_out_q <= 1'b0;
        end else if (ce) begin
            scl_p_q <= scl_in;
            sda_p_q <= sda_in;
            tick_q <= tick ? 8'h00 : tick_q + 8'h01;
        end
    end

    // Serial engine; data changes on a clock fall, or on the inter-edge watchdog at any clock level
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= TH_IDLE;
            bit_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            sda_oe_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                st_q <= TH_ADDR;
                bit_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (stop_det || edge_to) begin
                st_q <= TH_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                unique case (st_q)
                    TH_IDLE, TH_WAIT: begin
                    end
                    TH_ADDR, TH_WR: begin
                        if (scl_rise) begin
                            rx_q <= {rx_q[6:0], sda_in};
                            bit_q <= bit_q + 4'h1;
                        end else if (addr_hit) begin
                            st_q <= TH_ADDR_ACK;
                            sda_oe_q <= 1'b1;
                            dir_q <= rx_q[0];
                        end else if (byte_done) begin
                            st_q <= buf_push ? TH_WR_ACK : TH_WAIT;
                            sda_oe_q <= buf_push;
                        end
                    end
                    TH_ADDR_ACK, TH_WR_ACK, TH_RD_ACK: begin
                        if (st_q == TH_RD_ACK && scl_rise && sda_in) begin
                            st_q <= TH_WAIT;
                        end else if (rd_load) begin
                            st_q <= TH_RD;
                            tx_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                            bit_q <= `TH_FIRST_TX_BITS;
                        end else if (scl_fall) begin
                            st_q <= TH_WR;
                            sda_oe_q <= 1'b0;
                            bit_q <= 4'h0;
                        end
                    end
                    TH_RD: begin
                        if (byte_done) begin
                            st_q <= TH_RD_ACK;
                            sda_oe_q <= 1'b0;
                        end else if (scl_fall) begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= !tx_q[6];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Transfer window and inter-edge watchdog
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            xfer_q <= 1'b0;
            edge_tick_q <= 8'h00;
            eto_q <= 1'b0;
        end else if (ce) begin
            eto_q <= edge_to;
            if (addr_hit)
                xfer_q <= 1'b1;
            else if (end_evt)
                xfer_q <= 1'b0;
            if (addr_hit || scl_fall)
                edge_tick_q <= 8'h00;
            else if (xfer_q && tick && edge_tick_q != 8'hFF)
                edge_tick_q <= edge_tick_q + 8'h01;
        end
    end

    // Divided access bookkeeping; one resume timer serves both directions
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            res_run_q <= 1'b0;
            res_tick_q <= 8'h00;
            cmd_wait_q <= 1'b0;
            cmd_cont_q <= 1'b0;
            new_cmd_q <= 1'b0;
            abort_q <= 1'b0;
        end else if (ce) begin
            abort_q <= res_expire && cmd_wait_q;
            res_tick_q <= (res_run_q && tick) ? res_tick_q + 8'h01 : res_tick_q;
            if (wr_hit) begin
                new_cmd_q <= !cmd_wait_q;
                cmd_cont_q <= cmd_wait_q;
                cmd_wait_q <= 1'b0;
            end else if (buf_push) begin
                new_cmd_q <= 1'b0;
            end else if (wr_end) begin
                cmd_wait_q <= !cmd_cont_q;
                cmd_cont_q <= 1'b0;
            end else if (res_expire || cmd_done) begin
                cmd_wait_q <= 1'b0;
            end
            if (addr_hit || res_expire || cmd_done) begin
                res_run_q <= 1'b0;
            end else if ((wr_end && !cmd_cont_q) || (rd_end && rsp_split)) begin
                res_run_q <= 1'b1;
                res_tick_q <= 8'h00;
            end
        end
    end

    // Response delivery
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_pend_q <= 1'b0;
            rsp_cont_q <= 1'b0;
            rsp_cnt_q <= 8'h00;
            rdy_q <= 1'b0;
            flush_q <= 1'b0;
        end else if (ce) begin
            rdy_q <= rsp_take;
            flush_q <= (rd_end && !rsp_split && rsp_ok) || (res_expire && rsp_cont_q);
            if (cmd_done) begin
                rsp_pend_q <= 1'b1;
                rsp_cont_q <= 1'b0;
                rsp_cnt_q <= 8'h00;
            end else if (rd_end) begin
                rsp_cont_q <= rsp_split;
                rsp_pend_q <= rsp_split;
            end else if (res_expire && rsp_cont_q) begin
                rsp_pend_q <= 1'b0;
                rsp_cont_q <= 1'b0;
            end
            if (rsp_take)
                rsp_cnt_q <= rsp_cnt_q + 8'h01;
        end
    end

    // Command buffer storage, entry 0 feeds the executor
    genvar gi;
    generate
        for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_buf
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    buf_q[gi] <= 9'h000;
                end else if (ce) begin
                    if (buf_pop && gi < BUF_DEPTH - 1)
                        buf_q[gi] <= buf_q[(gi + 1) % BUF_DEPTH];
                    if (buf_push && wr_idx == CNT_W'(gi))
                        buf_q[gi] <= push_word;
                end
            end
        end
    endgenerate

    // Interrupt pin and masks; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            buf_cnt_q <= '0;
            cmd_valid_q <= 1'b0;
            irq_n_q <= 1'b1;
            mask_q <= `TH_MASK_RESET;
        end else if (ce) begin
            buf_cnt_q <= buf_cnt_d;
            cmd_valid_q <= buf_cnt_d != '0;
            irq_n_q <= !(irq_set || (!irq_n_q && !irq_clr));
            if (ctrl_we)
                mask_q <= ctrl_data[`TH_MASK_MSB:`TH_MASK_LSB];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_rd_release;
        ce && rd_hit && !irq_set |=> irq_out_n;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("irq not released on read");

    property p_done_irq;
        ce && cmd_done ##1 ce |-> !irq_out_n ##1 (!irq_out_n || $past(irq_clr));
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("completion irq missing");

    property p_tunnel_irq;
        ce && tunnel_detect && mask_q == 4'hF |=> !irq_out_n;
    endproperty
    a_tunnel_irq: assert property (p_tunnel_irq) else $error("tunnel irq masked");

    property p_mask;
        ce && irq_out_n && !cmd_done && !tunnel_detect && (rf_src & ~mask_q) == 4'h0
            |=> irq_out_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source raised irq");

    property p_field_irq;
        ce && rf_field_detect && irq_source_select[`TH_SRC_FIELD] && !mask_q[`TH_SRC_FIELD]
            |=> !irq_out_n;
    endproperty
    a_field_irq: assert property (p_field_irq) else $error("field irq missing");

    property p_addr_ack;
        ce && addr_hit |=> sda_oe && st_q == TH_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

    property p_edge_to;
        ce && edge_to |=> st_q == TH_IDLE && !sda_oe && edge_timeout;
    endproperty
    a_edge_to: assert property (p_edge_to) else $error("edge watchdog ignored");

    property p_abort;
        ce && res_expire && cmd_wait_q |=> cmd_abort && !cmd_wait_q;
    endproperty
    a_abort: assert property (p_abort) else $error("resume expiry not abandoned");

    property p_power_loss;
        ce && field_lost && !irq_set |=> irq_out_n;
    endproperty
    a_power_loss: assert property (p_power_loss) else $error("irq held without power");
endmodule

// ===== th_host_model.sv
// Host bus master model that clocks the serial port
`timescale 1ns/1ns
module th_host_model (
    // Clock
    input wire logic sys_clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // Data moves only while the clock is low, one cycle after its fall
    task automatic put_bit(input logic b);
        tk(1);
        sda_pull = ~b;
        tk(3);
        scl = 1'b1;
        tk(4);
        scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        tk(1);
        sda_pull = 1'b0;
        tk(3);
        scl = 1'b1;
        tk(3);
        b = sda;
        tk(1);
        scl = 1'b0;
    endtask
    task automatic start;
        sda_pull = 1'b0;
        scl = 1'b1;
        tk(2);
        sda_pull = 1'b1;
        tk(3);
        scl = 1'b0;
    endtask
    // Clock is left high afterwards, so the bus stands idle between frames
    task automatic stop;
        tk(1);
        sda_pull = 1'b1;
        tk(3);
        scl = 1'b1;
        tk(3);
        sda_pull = 1'b0;
        tk(3);
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        get_bit(a);
        ack = ~a;
    endtask
    task automatic rd_byte(output logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) get_bit(b[i]);
        put_bit(nack);
    endtask
endmodule

// ===== test_th_serial_irq_port.sv
// Self-checking bench for the tag host serial port and interrupt pin
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module test_th_serial_irq_port;
    localparam logic [6:0] ADDR = 7'h52;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ext = 1'b0;
    logic field = 1'b1;
    logic ctrl_we = 1'b0;
    logic [7:0] ctrl_data = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] ev = 4'h0;
    logic [15:0] rd_addr = 16'h0000;
    logic tunnel = 1'b0;
    logic cmd_ready = 1'b1;
    logic cmd_done = 1'b0;
    logic [7:0] dev_status = 8'h00;
    logic [7:0] rq [0:7];
    logic [8:0] cq [$];
    logic ce = 1'b1;
    int n_abort = 0;
    int n_tmo = 0;
    int n_flush = 0;
    logic [3:0] ak;
    int rn = 0;
    int ri = 0;
    int n_mismatch = 0;
    int checks_done = 0;
    wire logic scl, host_pull, sda, sda_out, sda_oe, irq_out_n, cmd_valid, cmd_first;
    wire logic cmd_abort, rsp_valid, rsp_ready, rsp_flush, edge_timeout;
    wire logic [3:0] irq_mask;
    wire logic [7:0] cmd_data, rsp_data;
    // Open-drain wire with pull-up
    assign sda = host_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    assign rsp_valid = ri < rn;
    assign rsp_data = rsp_valid ? rq[ri[2:0]] : 8'h00;
    always #25 sys_clk = ~sys_clk;
    // Executor stand-in: takes command bytes, steps the response stream
    always @(posedge sys_clk) begin
        if (cmd_valid && cmd_ready) cq.push_back({cmd_first, cmd_data});
        if (rsp_ready) ri <= ri + 1;
        if (cmd_abort) n_abort <= n_abort + 1;
        if (edge_timeout) n_tmo <= n_tmo + 1;
        if (rsp_flush) n_flush <= n_flush + 1;
    end
    th_host_model host_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(host_pull));
    th_serial_irq_port #(.SLAVE_ADDR(ADDR), .BUF_DEPTH(2)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_out_n(irq_out_n),
        .resume_wait_time(8'h0A), .inter_edge_wait_time(8'h02), .irq_source_select(sel),
        .read_irq_block_start(16'h0010), .read_irq_block_end(16'h0020),
        .external_supply(ext), .field_present(field), .ctrl_we(ctrl_we),
        .ctrl_data(ctrl_data), .irq_mask(irq_mask), .rf_write_start(ev[3]),
        .rf_read_resp_sent(ev[2]), .rf_read_addr(rd_addr), .rf_tx_done(ev[1]),
        .rf_field_detect(ev[0]), .tunnel_detect(tunnel), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_first(cmd_first), .cmd_ready(cmd_ready),
        .cmd_abort(cmd_abort), .cmd_done(cmd_done), .dev_status(dev_status),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
        .rsp_flush(rsp_flush), .edge_timeout(edge_timeout));
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic load(input logic [31:0] v, input int n);
        for (int k = 0; k < n; k++) rq[k] = v[31 - 8 * k -: 8];
        ri = 0;
        rn = n;
    endtask
    task automatic pulse_done;
        cmd_done = 1'b1;
        tk(1);
        cmd_done = 1'b0;
        tk(2);
    endtask
    // Field and supply both gone clears the pin
    task automatic clr;
        field = 1'b0;
        ext = 1'b0;
        tk(2);
        field = 1'b1;
        tk(1);
    endtask
    task automatic fire(input int s, input logic [15:0] a);
        rd_addr = a;
        ev = 4'h1 << s;
        tk(1);
        ev = 4'h0;
        tk(2);
    endtask
    task automatic set_mask(input logic [3:0] m);
        ctrl_we = 1'b1;
        ctrl_data = {m, 4'h0};
        tk(1);
        ctrl_we = 1'b0;
        tk(1);
        `CHK("irq_mask", m, irq_mask)
    endtask
    task automatic wr(input logic [23:0] d, input int n, output logic [3:0] acks);
        logic a;
        acks = 4'h0;
        host_u.start();
        host_u.wr_byte({ADDR, 1'b0}, a);
        acks[0] = a;
        for (int k = 0; k < n; k++) begin
            host_u.wr_byte(d[23 - 8 * k -: 8], a);
            acks[k + 1] = a;
        end
        host_u.stop();
        tk(4);
    endtask
    task automatic rdx(input int n, input logic [23:0] e);
        logic a;
        logic [7:0] b;
        host_u.start();
        host_u.wr_byte({ADDR, 1'b1}, a);
        `CHK("read addr ack", 1'b1, a)
        `CHK("irq release", 1'b1, irq_out_n)
        for (int k = 0; k < n; k++) begin
            host_u.rd_byte(b, k == n - 1);
            `CHK("read byte", e[23 - 8 * k -: 8], b)
        end
        host_u.stop();
        tk(4);
    endtask
    task automatic t_status;
        logic a;
        `CHK("irq idle", 1'b1, irq_out_n)
        `CHK("mask reset", 4'h0, irq_mask)
        host_u.start();
        host_u.wr_byte({7'h11, 1'b1}, a);
        `CHK("foreign addr ack", 1'b0, a)
        host_u.stop();
        dev_status = 8'hA5;
        rdx(1, 24'hA50000);
        $display("test status done");
    endtask
    task automatic t_normal;
        cq.delete();
        load(32'h3C112200, 3);
        wr(24'h789000, 2, ak);
        `CHK("write acks", 4'h7, ak[2:0])
        `CHK("cmd count", 2, cq.size())
        `CHK("cmd byte0", 9'h178, cq[0])
        `CHK("cmd byte1", 9'h090, cq[1])
        `CHK("irq before done", 1'b1, irq_out_n)
        pulse_done();
        `CHK("irq on done", 1'b0, irq_out_n)
        rdx(3, 24'h3C1122);
        $display("test normal done");
    endtask
    // Receiver stalls: two bytes fit, the third is refused
    task automatic t_full;
        cq.delete();
        load(32'h0, 0);
        cmd_ready = 1'b0;
        wr(24'h010203, 3, ak);
        `CHK("full acks", 4'h7, ak)
        `CHK("stalled valid", 1'b1, cmd_valid)
        cmd_ready = 1'b1;
        tk(6);
        `CHK("drained count", 2, cq.size())
        `CHK("drained valid", 1'b0, cmd_valid)
        pulse_done();
        clr();
        $display("test full done");
    endtask
    task automatic t_div_cmd;
        int a0;
        cq.delete();
        wr(24'h780000, 1, ak);
        tk(20);
        wr(24'h900000, 1, ak);
        `CHK("part1 byte", 9'h178, cq[0])
        `CHK("part2 byte", 9'h090, cq[1])
        pulse_done();
        clr();
        a0 = n_abort;
        wr(24'h780000, 1, ak);
        for (int k = 0; k < 400 && n_abort == a0; k++) tk(1);
        `CHK("abandon", 1, n_abort - a0)
        $display("test divided command done");
    endtask
    task automatic t_div_rsp;
        int f0;
        dev_status = 8'h50;
        load(32'h3C112233, 4);
        pulse_done();
        rdx(2, 24'h3C1100);
        tk(10);
        rdx(3, 24'h5B2233);
        // Part one only, then let the resume window run out
        load(32'h3C112233, 4);
        pulse_done();
        f0 = n_flush;
        rdx(2, 24'h3C1100);
        tk(300);
        `CHK("resume expiry flush", 1, n_flush - f0)
        $display("test divided response done");
    endtask
    task automatic t_irq;
        clr();
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 3; m++) begin
                sel = (m == 1) ? 4'h0 : 4'h1 << s;
                set_mask((m == 2) ? 4'h1 << s : 4'h0);
                fire(s, 16'h0020);
                `CHK("irq src", (m == 0) ? 1'b0 : 1'b1, irq_out_n)
                clr();
            end
        end
        sel = 4'h4;
        set_mask(4'h0);
        fire(2, 16'h0021);
        `CHK("irq out of block", 1'b1, irq_out_n)
        fire(2, 16'h0010);
        `CHK("irq in block", 1'b0, irq_out_n)
        clr();
        sel = 4'h0;
        set_mask(4'hF);
        tunnel = 1'b1;
        tk(1);
        tunnel = 1'b0;
        tk(2);
        `CHK("irq tunnel", 1'b0, irq_out_n)
        // Enable low freezes the pin through a power loss
        ce = 1'b0;
        clr();
        ce = 1'b1;
        `CHK("irq frozen", 1'b0, irq_out_n)
        clr();
        pulse_done();
        `CHK("irq serial", 1'b0, irq_out_n)
        clr();
        sel = 4'h1;
        set_mask(4'h0);
        ext = 1'b1;
        fire(0, 16'h0000);
        field = 1'b0;
        tk(3);
        `CHK("irq held", 1'b0, irq_out_n)
        ext = 1'b0;
        tk(3);
        `CHK("irq unpowered", 1'b1, irq_out_n)
        field = 1'b1;
        $display("test interrupts done");
    endtask
    // Host stalls while the port drives a zero data bit
    task automatic t_tmo;
        logic a;
        int t0;
        t0 = n_tmo;
        load(32'h0, 0);
        host_u.start();
        host_u.wr_byte({ADDR, 1'b1}, a);
        tk(2);
        `CHK("driving", 1'b1, sda_oe)
        tk(98);
        `CHK("edge watchdog", 1, n_tmo - t0)
        `CHK("released", 1'b0, sda_oe)
        host_u.stop();
        $display("test edge watchdog done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        tk(5);
        resetn = 1'b1;
        tk(2);
        t_status();
        t_normal();
        t_full();
        t_div_cmd();
        t_div_rsp();
        t_irq();
        t_tmo();
        end_sim();
    end
    // Whole run needs about 3300 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        $display("ERROR watchdog expected finish seen hang");
        end_sim();
    end
endmodule
